/* File: src/psi_cfg.svh */
// timing constants and counts for the status indicator block
`ifndef PSI_CFG_SVH
`define PSI_CFG_SVH
`define PSI_CLK_HZ 20000000
`define PSI_BLINK1_HZ 1
`define PSI_BLINK2_HZ 2
// half period in cycles for 50 percent duty
`define PSI_HALF1_CYC (`PSI_CLK_HZ / (2 * `PSI_BLINK1_HZ))
`define PSI_HALF2_CYC (`PSI_CLK_HZ / (2 * `PSI_BLINK2_HZ))
`define PSI_SYNC_RST 3'h0
`endif

/* File: src/psi_pkg.sv */
// types for the status indicator block
package psi_pkg;
    typedef enum logic [5:0] {
        LED_DARK = 6'b00_0001,
        LED_GREEN = 6'b00_0010,
        LED_BLINK_GREEN1 = 6'b00_0100,
        LED_BLINK_GREEN2 = 6'b00_1000,
        LED_AMBER = 6'b01_0000,
        LED_BLINK_AMBER1 = 6'b10_0000
    } psi_led_type;
endpackage

/* File: src/psi_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module psi_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // async in, filtered out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } psi_sync_state_type;
    psi_sync_state_type st_q;
    psi_sync_state_type st_d;
    // stage chain; first stage read only by second
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_q.s2[i] == st_q.s3[i])
            begin
                st_d.out[i] = st_q.s3[i];
            end
        end
    end
    // all bits start low
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
    assign sync_out = st_q.out;
endmodule
`default_nettype wire

/* File: src/psi_status.sv */
// power supply status indicator: alert line, led, latch and diagnostics
`timescale 1ns/1ns
`default_nettype none
`include "psi_cfg.svh"
// Contract
// - alert on any critical or warning event
// - alert sources: temp, faults, fan, eol
// - alert active low, open drain
// - alert together with any amber state
// - critical shutdown stores telemetry to nvm
// - record readable over smbus in standby
// - firmware accepted only in standby
// - led dark without ac anywhere
// - green 1hz in standby or cold redundant
// - solid amber on own ac loss
// - amber 1hz on running warnings
// - solid amber after critical shutdown
// - green 2hz during firmware update
// - main on only while power request low
// - over current latches output off
module psi_status #(
    parameter int HALF1_CYC = `PSI_HALF1_CYC,
    parameter int HALF2_CYC = `PSI_HALF2_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // supply state pins (asynchronous)
    input wire logic ac_present,
    input wire logic any_ac_present,
    input wire logic power_on_req_n,
    input wire logic main_in_reg,
    input wire logic cold_redundant,
    // critical event pins
    input wire logic over_current_fault,
    input wire logic over_voltage_fault,
    input wire logic under_voltage_fault,
    input wire logic general_fault,
    input wire logic fan_fail,
    // warning event pins
    input wire logic temp_warn,
    input wire logic power_warn,
    input wire logic current_warn,
    input wire logic fan_slow,
    input wire logic end_of_life,
    input wire logic env_out_of_range,
    // firmware controller (same clock)
    input wire logic fw_update_req,
    input wire logic fw_update_active,
    input wire logic diag_read_req,
    // outputs
    output logic main_enable,
    output logic alert_n_o,
    output logic alert_n_oe,
    output logic led_green,
    output logic led_amber,
    output logic diag_save,
    output logic diag_read_grant,
    output logic fw_update_grant
);
    localparam int NSYNC = 16;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] syn;
    // request enters inverted: sync flops reset low, so it reads released, no false edge
    assign raw = {ac_present, any_ac_present, !power_on_req_n, main_in_reg, cold_redundant,
        over_current_fault, over_voltage_fault, under_voltage_fault, general_fault,
        fan_fail, temp_warn, power_warn, current_warn, fan_slow, end_of_life,
        env_out_of_range};
    psi_sync #(.WIDTH(NSYNC)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(raw),
        .sync_out(syn)
    );
    logic s_ac, s_any_ac, s_req_on, s_inreg, s_cold;
    logic s_ocp, s_ovp, s_uvp, s_gen, s_fanf;
    logic s_tw, s_pw, s_cw, s_fs, s_eol, s_env;
    logic s_req_n;
    assign {s_ac, s_any_ac, s_req_on, s_inreg, s_cold, s_ocp, s_ovp, s_uvp, s_gen, s_fanf,
        s_tw, s_pw, s_cw, s_fs, s_eol, s_env} = syn;
    // back to pin polarity for the latch and enable logic
    assign s_req_n = !s_req_on;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic ocp_latch;
        logic crit_latch;
        logic req_n_prev;
        logic ac_prev;
        logic [31:0] cnt1;
        logic [31:0] cnt2;
        logic ph1;
        logic ph2;
        psi_pkg::psi_led_type led;
        logic main_en;
        logic alert_oe;
        logic green;
        logic amber;
        logic save;
        logic rd_grant;
        logic fw_grant;
    } psi_state_type;
    psi_state_type st_q;
    psi_state_type st_d;

    logic standby;
    logic warn_any;
    logic crit_now;
    // standby: standby rail up, main output off
    assign standby = s_ac && !st_q.main_en;
    assign warn_any = s_tw || s_pw || s_cw || s_fs || s_eol || s_env;
    assign crit_now = s_ocp || s_ovp || s_uvp || s_gen || s_fanf;

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic for latches, blink dividers, led and alert
    always_comb
    begin
        st_d = st_q;
        st_d.req_n_prev = s_req_n;
        st_d.ac_prev = s_ac;
        st_d.save = 1'b0;
        // divide clock for 50 percent blinks
        if (st_q.cnt1 >= 32'(HALF1_CYC - 1))
        begin
            st_d.cnt1 = '0;
            st_d.ph1 = !st_q.ph1;
        end
        else
        begin
            st_d.cnt1 = st_q.cnt1 + 32'd1;
        end
        if (st_q.cnt2 >= 32'(HALF2_CYC - 1))
        begin
            st_d.cnt2 = '0;
            st_d.ph2 = !st_q.ph2;
        end
        else
        begin
            st_d.cnt2 = st_q.cnt2 + 32'd1;
        end
        // latch clears on request release (rising edge) or ac loss; new fault wins
        if ((s_req_n && !st_q.req_n_prev) || !s_ac)
        begin
            st_d.ocp_latch = 1'b0;
            st_d.crit_latch = 1'b0;
        end
        if (s_ocp)
        begin
            st_d.ocp_latch = 1'b1;
        end
        // one save pulse on entry to critical shutdown
        if (crit_now && s_ac)
        begin
            st_d.crit_latch = 1'b1;
            st_d.save = !st_q.crit_latch;
        end
        // main output follows request, blocked by latched faults
        st_d.main_en = !s_req_n && s_ac && !st_d.ocp_latch && !st_d.crit_latch
            && !fw_update_active;
        st_d.fw_grant = fw_update_req && standby;
        // record readable whenever standby rail is up
        st_d.rd_grant = diag_read_req && s_ac;
        if (!s_any_ac)
        begin
            st_d.led = psi_pkg::LED_DARK;
        end
        else if (fw_update_active)
        begin
            st_d.led = psi_pkg::LED_BLINK_GREEN2;
        end
        else if (st_d.crit_latch)
        begin
            st_d.led = psi_pkg::LED_AMBER;
        end
        else if (!s_ac)
        begin
            st_d.led = psi_pkg::LED_AMBER;
        end
        else if (warn_any)
        begin
            st_d.led = psi_pkg::LED_BLINK_AMBER1;
        end
        else if (!st_q.main_en || s_cold || !s_inreg)
        begin
            st_d.led = psi_pkg::LED_BLINK_GREEN1;
        end
        else
        begin
            st_d.led = psi_pkg::LED_GREEN;
        end
        st_d.green = 1'b0;
        st_d.amber = 1'b0;
        case (st_d.led)
            psi_pkg::LED_GREEN: st_d.green = 1'b1;
            psi_pkg::LED_BLINK_GREEN1: st_d.green = st_d.ph1;
            psi_pkg::LED_BLINK_GREEN2: st_d.green = st_d.ph2;
            psi_pkg::LED_AMBER: st_d.amber = 1'b1;
            psi_pkg::LED_BLINK_AMBER1: st_d.amber = st_d.ph1;
            default: st_d.green = 1'b0;
        endcase
        // alert on any event and every amber state; drive low only
        // events still alert while a firmware blink hides the amber
        st_d.alert_oe = (st_d.led == psi_pkg::LED_AMBER)
            || (st_d.led == psi_pkg::LED_BLINK_AMBER1)
            || warn_any || crit_now || st_d.crit_latch;
    end

    // one register for all state; request starts released (high)
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
            st_q.req_n_prev <= 1'b1;
            st_q.led <= psi_pkg::LED_DARK;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops, except alert data, which is tied low
    assign main_enable = st_q.main_en;
    assign alert_n_o = 1'b0;
    assign alert_n_oe = st_q.alert_oe;
    assign led_green = st_q.green;
    assign led_amber = st_q.amber;
    assign diag_save = st_q.save;
    assign diag_read_grant = st_q.rd_grant;
    assign fw_update_grant = st_q.fw_grant;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence crit_seen;
        crit_now && s_ac && !st_q.crit_latch;
    endsequence
    a_alert_amber: assert property ((led_amber ||
        st_q.led == psi_pkg::LED_BLINK_AMBER1) |-> alert_n_oe) else $error("alert not with amber");
    a_alert_warn: assert property (s_any_ac && s_ac && warn_any |=> alert_n_oe)
        else $error("warning without alert");
    a_save_pulse: assert property (crit_seen |=> diag_save ##1 !diag_save)
        else $error("save pulse wrong");
    a_fw_standby: assert property (fw_update_grant |-> $past(standby))
        else $error("firmware outside standby");
    a_led_dark: assert property (!s_any_ac |=> !led_green && !led_amber)
        else $error("led lit without ac");
    a_ocp_off: assert property (s_ocp |=> !main_enable)
        else $error("main on after over current");
    a_req_off: assert property (s_req_n |=> !main_enable)
        else $error("main on with request high");
    a_crit_amber: assert property (s_any_ac && !fw_update_active && st_q.crit_latch
        && !(s_req_n && !st_q.req_n_prev) |=> led_amber) else $error("critical not amber");
endmodule
`default_nettype wire

/* File: verif/psi_host.sv */
// host-side model: power request drive and alert line pull-up
`timescale 1ns/1ns
`default_nettype none
module psi_host (
    // host command
    input wire logic want_on,
    // alert pin pieces from the supply
    input wire logic alert_n_o,
    input wire logic alert_n_oe,
    // board lines
    output logic power_on_req_n,
    output logic alert_line
);
    // power request drive
    // pulled low for on; the pull-up wins once released
    assign power_on_req_n = want_on ? 1'h0 : 1'h1;
    // alert pull-up
    // board pull-up unless the supply sinks the line
    assign alert_line = alert_n_oe ? alert_n_o : 1'h1;
endmodule
`default_nettype wire

/* File: verif/psi_status_tb.sv */
// self-checking bench for the status indicator block
`timescale 1ns/1ns
`default_nettype none
module psi_status_tb;
    typedef struct packed {
        logic [4:0] crit;
        logic [5:0] warn;
        logic [5:0] st;
        logic [5:0] led;
        logic main;
    } psi_row_type;
    // short blink halves keep each row to a few dozen cycles
    localparam int LIMIT = 3000;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [4:0] crit = 5'h00;
    logic [5:0] warn = 6'h00;
    logic ac = 1'h1, any_ac = 1'h1, want_on = 1'h0, in_reg = 1'h1, cold = 1'h0;
    logic fw_act = 1'h0, fw_req = 1'h1, diag_req = 1'h1;
    logic power_on_req_n, alert_line, main_enable, alert_n_o, alert_n_oe;
    logic led_green, led_amber, diag_save, diag_read_grant, fw_update_grant;
    int err_count = 0, checks_done = 0, cyc = 0, saves = 0, s;
    psi_row_type rows [21];
    ////////////////////////////////////////////////////////////////////////////////
    psi_host host (.want_on(want_on), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
        .power_on_req_n(power_on_req_n), .alert_line(alert_line));
    psi_status #(.HALF1_CYC(8), .HALF2_CYC(4)) uut (.clk(clk), .sys_rst(sys_rst),
        .ac_present(ac), .any_ac_present(any_ac), .power_on_req_n(power_on_req_n),
        .main_in_reg(in_reg), .cold_redundant(cold), .over_current_fault(crit[0]),
        .over_voltage_fault(crit[1]), .under_voltage_fault(crit[2]), .general_fault(crit[3]),
        .fan_fail(crit[4]), .temp_warn(warn[0]), .power_warn(warn[1]), .current_warn(warn[2]),
        .fan_slow(warn[3]), .end_of_life(warn[4]), .env_out_of_range(warn[5]),
        .fw_update_req(fw_req), .fw_update_active(fw_act), .diag_read_req(diag_req),
        .main_enable(main_enable), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
        .led_green(led_green), .led_amber(led_amber), .diag_save(diag_save),
        .diag_read_grant(diag_read_grant), .fw_update_grant(fw_update_grant));
    ////////////////////////////////////////////////////////////////////////////////
    // free-running clock, 50 ns
    initial
    begin
        forever #25 clk = ~clk;
    end
    // cycle ceiling and store-pulse count, off the launching edge
    always @(negedge clk)
    begin
        cyc <= cyc + 1;
        saves <= saves + diag_save;
        if (cyc == LIMIT)
        begin
            err_count = err_count + 1;
            final_report();
        end
    end
    task automatic final_report();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic chk_led(input logic [5:0] e, input logic [5:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD led exp %h got %h", e, g);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one 16-cycle window: high counts and toggles tell solid from each blink
    task automatic observe(output logic [5:0] led, output logic al);
        int g, a, tg, ta, lo;
        logic pg, pa;
        g = 0; a = 0; tg = 0; ta = 0; lo = 0;
        pg = led_green;
        pa = led_amber;
        repeat (16)
        begin
            @(negedge clk);
            g += led_green; a += led_amber; lo += !alert_line;
            tg += (led_green != pg); ta += (led_amber != pa);
            pg = led_green;
            pa = led_amber;
        end
        led = 6'h00;
        if (g == 0 && a == 0) led = psi_pkg::LED_DARK;
        if (a == 0 && g == 16) led = psi_pkg::LED_GREEN;
        if (a == 0 && g == 8 && tg == 2) led = psi_pkg::LED_BLINK_GREEN1;
        if (a == 0 && g == 8 && tg == 4) led = psi_pkg::LED_BLINK_GREEN2;
        if (g == 0 && a == 16) led = psi_pkg::LED_AMBER;
        if (g == 0 && a == 8 && ta == 2) led = psi_pkg::LED_BLINK_AMBER1;
        al = (lo == 16) ? 1'h0 : (lo == 0) ? 1'h1 : 1'hx;
    endtask
    // idle with request released clears any latch, then the row is applied
    task automatic apply(input psi_row_type r);
        logic [5:0] led;
        logic al;
        logic ea;
        crit = 5'h00; warn = 6'h00; fw_act = 1'h0; want_on = 1'h0; ac = 1'h1; any_ac = 1'h1;
        cycles(8);
        crit = r.crit;
        warn = r.warn;
        {ac, any_ac, want_on, in_reg, cold, fw_act} = r.st;
        cycles(12);
        observe(led, al);
        chk_led(r.led, led);
        ea = !(r.led == psi_pkg::LED_AMBER || r.led == psi_pkg::LED_BLINK_AMBER1);
        chk_bit("alert", ea && r.warn == 6'h00 && r.crit == 5'h00, al);
        chk_bit("main", r.main, main_enable);
        chk_bit("fw", r.st[5] & !r.main, fw_update_grant);
        if (!r.main) chk_bit("diag", r.st[5], diag_read_grant);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: reset checks, rows, then request-drop and latch cases
    initial
    begin
        rows[0] = '{5'h00, 6'h00, 6'h00, psi_pkg::LED_DARK, 1'h0};
        rows[1] = '{5'h00, 6'h00, 6'h34, psi_pkg::LED_BLINK_GREEN1, 1'h0};
        rows[2] = '{5'h00, 6'h00, 6'h3c, psi_pkg::LED_GREEN, 1'h1};
        rows[3] = '{5'h00, 6'h00, 6'h3e, psi_pkg::LED_BLINK_GREEN1, 1'h1};
        rows[4] = '{5'h00, 6'h00, 6'h38, psi_pkg::LED_BLINK_GREEN1, 1'h1};
        rows[5] = '{5'h00, 6'h00, 6'h14, psi_pkg::LED_AMBER, 1'h0};
        rows[6] = '{5'h00, 6'h00, 6'h35, psi_pkg::LED_BLINK_GREEN2, 1'h0};
        rows[7] = '{5'h00, 6'h01, 6'h14, psi_pkg::LED_AMBER, 1'h0};
        rows[8] = '{5'h10, 6'h3f, 6'h3c, psi_pkg::LED_AMBER, 1'h0};
        for (int i = 0; i < 6; i++)
            rows[9 + i] = '{5'h00, 6'(1 << i), 6'h3c, psi_pkg::LED_BLINK_AMBER1, 1'h1};
        for (int i = 0; i < 5; i++)
            rows[15 + i] = '{5'(1 << i), 6'h00, 6'h3c, psi_pkg::LED_AMBER, 1'h0};
        rows[20] = '{5'h00, 6'h01, 6'h35, psi_pkg::LED_BLINK_GREEN2, 1'h0};
        cycles(12);
        chk_bit("rst_alert", 1'h0, alert_n_oe);
        chk_bit("rst_main", 1'h0, main_enable);
        cycles(4);
        sys_rst = 1'h0;
        cycles(8);
        foreach (rows[i]) apply(rows[i]);
        // clear the last row's warning and update; requests dropped in standby
        crit = 5'h00;
        warn = 6'h00;
        fw_act = 1'h0;
        want_on = 1'h0;
        fw_req = 1'h0;
        diag_req = 1'h0;
        cycles(8);
        chk_bit("fw_idle", 1'h0, fw_update_grant);
        chk_bit("diag_idle", 1'h0, diag_read_grant);
        fw_req = 1'h1;
        diag_req = 1'h1;
        // over-current pulse: one store, output held off after the pin clears
        want_on = 1'h1;
        cycles(12);
        chk_bit("main_on", 1'h1, main_enable);
        s = saves;
        crit[0] = 1'h1;
        cycles(6);
        crit[0] = 1'h0;
        cycles(14);
        chk_bit("save_once", 1'h1, saves - s == 1);
        chk_bit("latched", 1'h0, main_enable);
        chk_bit("alert_held", 1'h0, alert_line);
        want_on = 1'h0;
        cycles(8);
        want_on = 1'h1;
        cycles(12);
        chk_bit("rearm_req", 1'h1, main_enable);
        crit[0] = 1'h1;
        cycles(6);
        crit[0] = 1'h0;
        cycles(8);
        ac = 1'h0;
        cycles(8);
        ac = 1'h1;
        cycles(12);
        chk_bit("rearm_ac", 1'h1, main_enable);
        final_report();
    end
endmodule
`default_nettype wire
